// ### hw/video_port_regs.svh
`ifndef VIDEO_PORT_REGS_SVH
`define VIDEO_PORT_REGS_SVH
// Serial packet layout
`define PKT_BITS        12
`define PKT_START_POS   0
`define PKT_LV_POS      9
`define PKT_FV_POS      10
`define PKT_STOP_POS    11
`define PKT_START_VAL   1'h1
`define PKT_STOP_VAL    1'h0
// Clock relations
`define MASTER_CLK_MHZ  27
`define SER_CLK_MHZ     324
`define SYS_CLK_MHZ     100
`define SLOT_LOAD       4'h0
`define SLOT_HALF       4'h6
// Line timing, 525-line system
`define L525_LINES      10'h20D
`define L525_F1_END     10'h003
`define L525_F1_BEGIN   10'h10A
`define L525_A0_BEGIN   10'h014
`define L525_A0_END     10'h107
`define L525_A1_BEGIN   10'h11B
`define L525_IMG0       10'h015
`define L525_IMG1       10'h11B
// Line timing, 625-line system
`define L625_LINES      10'h271
`define L625_F1_BEGIN   10'h139
`define L625_A0_BEGIN   10'h017
`define L625_A0_END     10'h136
`define L625_A1_BEGIN   10'h150
`define L625_A1_END     10'h26F
`define L625_IMG0       10'h02F
`define L625_IMG1       10'h168
// Image geometry
`define IMG_ROWS_FIELD  10'h0F0
`define IMG_ROW_LAST    9'h1DF
`define SAV_LEN         11'h004
// Code and fill bytes
`define CODE_FF         8'hFF
`define CODE_00         8'h00
`define FILL_C          8'h80
`define FILL_Y          8'h10
`endif

// ### hw/video_port_pkg.sv
package video_port_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic       lv;
        logic       fv;
    } vbyte_t;
    typedef struct packed {
        logic       din_clk;
        logic [7:0] din;
        logic       ser_en;
        logic       standby;
        logic       std_sel;
        logic       hmirror;
    } pins_t;
endpackage

// ### hw/interlaced_video_output_port.sv
`include "video_port_regs.svh"

module vid_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic         sys_clk,   // Clock
    input  wire logic         rstn,      // Async reset, low
    input  wire logic         flush,     // Empty the buffer
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Room available
    input  wire logic [W-1:0] in_data,   // Write data
    output logic              out_valid, // Data available
    input  wire logic         out_ready, // Read accept
    output logic [W-1:0]      out_data   // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    wire          full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire          empty = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge sys_clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (in_valid && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// How it works
// - Each serial packet is twelve bits, start bit one, stop bit zero.
// - Video byte follows the start bit, least significant bit first, bits 1 to 8.
// - Line-valid goes in bit 9, frame-valid in bit 10, before the stop bit.
// - Shift clock is twelve times the master clock: one packet per master period.
// - For CCIR output the bit rate is 324 MHz from a 27 MHz master.
// - Serial output idles unless the serial enable pin is asserted.
// - A configuration bit turns serial output off despite the enable pin.
// - Standby turns the serial output off.
// - Horizontal flag is one in end codes, zero in start codes, every line.
// - 525-line field and blanking flags follow the fixed line table.
// - 625-line field and blanking flags follow the fixed line table.
// - 525-line images get three black lines at the bottom.
// - 625-line images show 480 rows with 24 black lines above and below.
// - A select pin picks 525-line or 625-line operation at start-up.
// - External CCIR bytes from the parallel input can feed the output stream.
// - A select bit samples the parallel input with its strobe or master clock.
// - A select bit picks rising or falling sampling edge.
// - By default fields read odd and even rows, true interlace.
// - Horizontal mirror comes from a pin or a configuration bit.
// - Vertical mirror comes from a configuration bit, in every format.
// - Parallel output also carries progressive raw pixels in stand-alone mode.
module interlaced_video_output_port
    import video_port_pkg::*;
#(
    parameter logic [10:0] LINE_LEN_525 = 11'h6B4,
    parameter logic [10:0] LINE_LEN_625 = 11'h6C0,
    parameter logic [10:0] ACT_BYTES    = 11'h5A0,
    parameter int          FIFO_DEPTH   = 32
) (
    input  wire logic       sys_clk,                   // Bit clock, one packet per 12 edges
    input  wire logic       rstn,                      // Async reset, low
    input  wire logic       video_standard_select_pin, // 1 selects 625-line start-up
    input  wire logic       serial_enable_pin,         // Serial output enable
    input  wire logic       standby_pin,               // Standby request
    input  wire logic       horizontal_mirror_pin,     // Mirror columns
    input  wire logic       cfg_serial_disable,        // Serial output off
    input  wire logic       cfg_din_strobe_sel,        // 1 samples input with strobe
    input  wire logic       cfg_din_falling,           // 1 samples on falling edge
    input  wire logic       cfg_h_mirror,              // Mirror columns
    input  wire logic       cfg_v_mirror,              // Mirror rows
    input  wire logic       cfg_ext_mux,               // Active video from input port
    input  wire logic       cfg_raw_mode,              // Progressive raw output
    input  wire logic       din_clk,                   // Input port strobe
    input  wire logic [7:0] din,                       // Input port bytes
    input  wire logic       pix_valid,                 // Pixel byte offered
    output logic            pix_ready,                 // Pixel byte taken
    input  wire logic [7:0] pix_data,                  // Pixel byte
    output logic            line_req,                  // Row fetch request pulse
    output logic [8:0]      req_row,                   // Row to fetch
    output logic            req_reverse,               // Fetch columns reversed
    output logic [7:0]      pout_data,                 // Parallel output byte
    output logic            line_valid_flag,           // Parallel line valid
    output logic            frame_valid_flag,          // Parallel frame valid
    output logic            serial_out,                // Serial data
    output logic            serial_out_complement,     // Serial data inverted
    output logic            serial_active,             // Serial link running
    output logic            std_625                    // 625-line operation
);
    pins_t pin_raw;
    pins_t s1;
    pins_t s2;
    pins_t s3;
    pins_t pin;
    assign pin_raw = '{din_clk: din_clk, din: din, ser_en: serial_enable_pin,
                       standby: standby_pin, std_sel: video_standard_select_pin,
                       hmirror: horizontal_mirror_pin};

    // Three-stage pin sampling; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < $bits(pins_t); gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    s1[gi]  <= 1'b0;
                    s2[gi]  <= 1'b0;
                    s3[gi]  <= 1'b0;
                    pin[gi] <= 1'b0;
                end else begin
                    s1[gi] <= pin_raw[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi]) begin
                        pin[gi] <= s3[gi];
                    end
                end
            end
        end
    endgenerate

    logic [2:0] start_cnt;
    logic       std_taken;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            start_cnt <= 3'h0;
            std_taken <= 1'b0;
            std_625   <= 1'b0;
        end else if (!std_taken) begin
            start_cnt <= start_cnt + 3'h1;
            if (start_cnt == 3'h4) begin
                std_625   <= pin.std_sel;
                std_taken <= 1'b1;
            end
        end
    end

    logic [3:0]  slot;
    logic [10:0] byte_idx;
    logic [9:0]  line;
    wire         load     = (slot == `SLOT_LOAD);
    wire  [10:0] line_len = std_625 ? LINE_LEN_625 : LINE_LEN_525;
    wire  [9:0]  n_lines  = std_625 ? `L625_LINES : `L525_LINES;
    wire  [10:0] hbl      = line_len - ACT_BYTES;
    wire  [10:0] sav0     = hbl - `SAV_LEN;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            slot <= `SLOT_LOAD;
        end else if (slot == 4'(`PKT_BITS - 1)) begin
            slot <= `SLOT_LOAD;
        end else begin
            slot <= slot + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            byte_idx <= 11'h000;
            line     <= 10'h001;
        end else if (load && std_taken) begin
            if (byte_idx == line_len - 11'h001) begin
                byte_idx <= 11'h000;
                line     <= (line == n_lines) ? 10'h001 : line + 10'h001;
            end else begin
                byte_idx <= byte_idx + 11'h001;
            end
        end
    end

    logic       f_flag;
    logic       v_flag;
    logic       img_line;
    logic [9:0] img_r;
    always_comb begin
        img_r = 10'h000;
        if (std_625) begin
            f_flag = (line >= `L625_F1_BEGIN);
            v_flag = !(((line >= `L625_A0_BEGIN) && (line <= `L625_A0_END)) ||
                       ((line >= `L625_A1_BEGIN) && (line <= `L625_A1_END)));
            // 24 black lines pad each side of the 240 image lines of a field
            if ((line >= `L625_IMG0) && (line < `L625_IMG0 + `IMG_ROWS_FIELD)) begin
                img_r = line - `L625_IMG0;
            end else begin
                img_r = line - `L625_IMG1;
            end
            img_line = ((line >= `L625_IMG0) && (line < `L625_IMG0 + `IMG_ROWS_FIELD)) ||
                       ((line >= `L625_IMG1) && (line < `L625_IMG1 + `IMG_ROWS_FIELD));
        end else begin
            f_flag = (line <= `L525_F1_END) || (line >= `L525_F1_BEGIN);
            v_flag = !(((line >= `L525_A0_BEGIN) && (line <= `L525_A0_END)) ||
                       (line >= `L525_A1_BEGIN));
            // Image ends three lines before each field's active end
            if ((line >= `L525_IMG0) && (line < `L525_IMG0 + `IMG_ROWS_FIELD)) begin
                img_r = line - `L525_IMG0;
            end else begin
                img_r = line - `L525_IMG1;
            end
            img_line = ((line >= `L525_IMG0) && (line < `L525_IMG0 + `IMG_ROWS_FIELD)) ||
                       ((line >= `L525_IMG1) && (line < `L525_IMG1 + `IMG_ROWS_FIELD));
        end
    end

    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       fifo_pop;
    wire        in_act   = (byte_idx >= hbl);
    wire        img_act  = in_act && img_line;
    wire        frame_go = load && (byte_idx == 11'h000) && (line == 10'h001);

    vid_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .flush     (frame_go),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    logic din_clk_d;
    logic din_take;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            din_clk_d <= 1'b0;
        end else begin
            din_clk_d <= pin.din_clk;
        end
    end
    always_comb begin
        if (cfg_din_strobe_sel) begin
            din_take = cfg_din_falling ? (din_clk_d && !pin.din_clk)
                                       : (!din_clk_d && pin.din_clk);
        end else begin
            din_take = cfg_din_falling ? (slot == `SLOT_HALF) : load;
        end
    end

    // External bytes replace sensor pixels as active video content
    assign fifo_in_valid = cfg_ext_mux ? din_take : pix_valid;
    assign fifo_in_data  = cfg_ext_mux ? pin.din : pix_data;
    assign pix_ready     = !cfg_ext_mux && fifo_in_ready;
    assign fifo_pop      = load && img_act && fifo_out_valid;

    vbyte_t cur;
    logic   h_flag;
    logic   [7:0] xy;
    logic   [7:0] fill;
    always_comb begin
        h_flag = (byte_idx < `SAV_LEN);
        xy     = {1'b1, f_flag, v_flag, h_flag, v_flag ^ h_flag, f_flag ^ h_flag,
                  f_flag ^ v_flag, f_flag ^ v_flag ^ h_flag};
        fill   = byte_idx[0] ? `FILL_Y : `FILL_C;
        cur    = '{data: fill, lv: in_act && !v_flag, fv: !v_flag};
        if (cfg_raw_mode) begin
            cur.data = (img_act && fifo_out_valid) ? fifo_out_data : `CODE_00;
            cur.lv   = img_act;
            cur.fv   = img_line;
        end else if ((byte_idx == 11'h000) || (byte_idx == sav0)) begin
            cur.data = `CODE_FF;
        end else if ((byte_idx == 11'h003) || (byte_idx == sav0 + 11'h003)) begin
            cur.data = xy;
        end else if ((byte_idx < 11'h003) || ((byte_idx > sav0) && !in_act)) begin
            cur.data = `CODE_00;
        end else if (img_act && fifo_out_valid) begin
            cur.data = fifo_out_data;
        end
    end

    logic [8:0] row_seq;
    always_comb begin
        if (cfg_raw_mode) begin
            row_seq = f_flag ? 9'(img_r) + 9'(`IMG_ROWS_FIELD) : 9'(img_r);
        end else begin
            row_seq = {img_r[7:0], f_flag};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            line_req    <= 1'b0;
            req_row     <= 9'h000;
            req_reverse <= 1'b0;
        end else begin
            line_req <= load && std_taken && (byte_idx == 11'h000) && img_line;
            if (load && (byte_idx == 11'h000)) begin
                req_row     <= cfg_v_mirror ? `IMG_ROW_LAST - row_seq : row_seq;
                req_reverse <= cfg_h_mirror || pin.hmirror;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pout_data        <= 8'h00;
            line_valid_flag  <= 1'b0;
            frame_valid_flag <= 1'b0;
        end else if (load) begin
            pout_data        <= cur.data;
            line_valid_flag  <= cur.lv;
            frame_valid_flag <= cur.fv;
        end
    end

    wire         ser_ok = pin.ser_en && !cfg_serial_disable && !pin.standby;
    logic [11:0] ser_bits;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ser_bits      <= 12'h000;
            serial_active <= 1'b0;
        end else if (load) begin
            serial_active <= ser_ok;
            if (ser_ok) begin
                ser_bits <= {`PKT_STOP_VAL, cur.fv, cur.lv, cur.data, `PKT_START_VAL};
            end else begin
                ser_bits <= 12'h000;
            end
        end else begin
            ser_bits <= {1'b0, ser_bits[11:1]};
        end
    end
    assign serial_out            = ser_bits[0];
    assign serial_out_complement = serial_active && !ser_bits[0];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_packet_load;
        load && ser_ok;
    endsequence
    sequence s_byte_bits;
        (serial_out == pout_data[0]) ##1 (serial_out == pout_data[1]) ##6
        (serial_out == pout_data[7]);
    endsequence

    property p_start_stop;
        s_packet_load |=> serial_out ##11 !serial_out;
    endproperty
    a_start_stop: assert property (p_start_stop) else $error("bad start or stop bit");

    property p_byte_lsb_first;
        s_packet_load |=> ##1 s_byte_bits;
    endproperty
    a_byte_lsb_first: assert property (p_byte_lsb_first) else $error("bad byte order");

    property p_flag_bits;
        s_packet_load |=> ##9 (serial_out == line_valid_flag) ##1
                               (serial_out == frame_valid_flag);
    endproperty
    a_flag_bits: assert property (p_flag_bits) else $error("bad flag bits");

    property p_packet_period;
        load |=> (!load) [*8] ##1 (!load) [*3] ##1 load;
    endproperty
    a_packet_period: assert property (p_packet_period) else $error("slot not 12");

    property p_serial_off;
        (load && !ser_ok) |=> (!serial_active && !serial_out) [*8];
    endproperty
    a_serial_off: assert property (p_serial_off) else $error("serial not off");

    property p_h_flag;
        (!cfg_raw_mode && (byte_idx == 11'h003)) |-> cur.data[4] && cur.data[7];
    endproperty
    a_h_flag: assert property (p_h_flag) else $error("bad end code flag");

    property p_h_flag_sav;
        (!cfg_raw_mode && (byte_idx == sav0 + 11'h003)) |-> !cur.data[4];
    endproperty
    a_h_flag_sav: assert property (p_h_flag_sav) else $error("bad start code flag");

    property p_table_525;
        (std_taken && !std_625 && (line == 10'h10B)) |-> f_flag && v_flag;
    endproperty
    a_table_525: assert property (p_table_525) else $error("525 table wrong");

    property p_table_625;
        (std_taken && std_625 && (line == 10'h139)) |-> f_flag && v_flag;
    endproperty
    a_table_625: assert property (p_table_625) else $error("625 table wrong");

    property p_pad_black;
        (load && !cfg_raw_mode && in_act && !img_line) |=> (pout_data == `FILL_C) ||
                                                           (pout_data == `FILL_Y);
    endproperty
    a_pad_black: assert property (p_pad_black) else $error("pad not black");

    property p_mirror;
        line_req |-> (req_reverse == ($past(cfg_h_mirror) || $past(pin.hmirror))) &&
                     (cfg_raw_mode || (req_row[0] == ($past(f_flag) ^ $past(cfg_v_mirror))));
    endproperty
    a_mirror: assert property (p_mirror) else $error("bad mirror request");
endmodule

// ### tb/video_link_partner.sv
module video_link_partner
    import video_port_pkg::*;
(
    input  wire logic       sys_clk,   // Clock
    input  wire logic       rstn,      // Async reset, low
    input  wire logic       ser_in,    // Serial data
    input  wire logic       ser_inv,   // Serial data inverted
    input  wire logic       ser_on,    // Link running
    input  wire vbyte_t     par,       // Parallel byte and flags
    input  wire logic       pix_ready, // Pixel byte taken
    output logic            pix_valid, // Pixel byte offered
    output logic [7:0]      pix_data,  // Pixel byte
    output logic            pkt_stb,   // Packet complete
    output logic [11:0]     pkt,       // Packet, first bit in bit 0
    output vbyte_t          pkt_ref,   // Parallel word at start bit
    output logic            inv_ok     // Complement matched on every cycle while link running
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  bcnt;
    logic [11:0] shreg;
    logic [1:0]  gap;

    // Twelve bits per packet, aligned on link start
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bcnt <= 4'h0;
            shreg <= 12'h000;
            pkt <= 12'h000;
            pkt_stb <= 1'b0;
            pkt_ref <= '0;
            inv_ok <= 1'b1;
        end else begin
            pkt_stb <= 1'b0;
            if (ser_on && ser_inv !== !ser_in)
                inv_ok <= 1'b0;
            if (!ser_on)
                bcnt <= 4'h0;
            else begin
                shreg[bcnt] <= ser_in;
                if (bcnt == 4'h0)
                    pkt_ref <= par;
                if (bcnt == 4'hB) begin
                    pkt <= {ser_in, shreg[10:0]};
                    pkt_stb <= 1'b1;
                    bcnt <= 4'h0;
                end else
                    bcnt <= bcnt + 4'h1;
            end
        end
    end

    // Pixel source, idles after every fourth byte
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pix_valid <= 1'b0;
            pix_data <= 8'h00;
            gap <= 2'h0;
        end else if (pix_valid && pix_ready) begin
            pix_data <= pix_data + 8'h01;
            gap <= gap + 2'h1;
            pix_valid <= (gap != 2'h3);
        end else if (!pix_valid)
            pix_valid <= 1'b1;
    end
endmodule

// ### tb/testbench.sv
module testbench
    import video_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rstn, std_pin, en_pin, stby, hm_pin, cfg_dis, cfg_hm, cfg_vm, cfg_mux;
    logic        pix_valid, pix_ready, line_req, req_reverse, lv, fv, ser, ser_n, ser_act;
    logic        std_625, pkt_stb, inv_ok, synced, lastv, hx, img_pend, img_line, have_prev;
    logic        scan_on, p625, css, cfe, craw, dck;
    logic [7:0]  pix_data, pout_data, prev, din;
    logic [8:0]  req_row, rw;
    logic [11:0] pkt, pe;
    logic [23:0] hist;
    logic [1:0]  fvx;
    vbyte_t      pout_word, pkt_ref;
    int          n_fail, n_checks, cur_line, n_req, first_req, last_req, act_left, pk_cnt, c0;

    assign pout_word = {pout_data, lv, fv};

    interlaced_video_output_port #(.LINE_LEN_525(11'h00C), .LINE_LEN_625(11'h00C),
        .ACT_BYTES(11'h004), .FIFO_DEPTH(32)) u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .video_standard_select_pin(std_pin),
        .serial_enable_pin(en_pin), .standby_pin(stby), .horizontal_mirror_pin(hm_pin),
        .cfg_serial_disable(cfg_dis), .cfg_din_strobe_sel(css), .cfg_din_falling(cfe),
        .cfg_h_mirror(cfg_hm), .cfg_v_mirror(cfg_vm), .cfg_ext_mux(cfg_mux),
        .cfg_raw_mode(craw), .din_clk(dck), .din(din), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data), .line_req(line_req), .req_row(req_row),
        .req_reverse(req_reverse), .pout_data(pout_data), .line_valid_flag(lv),
        .frame_valid_flag(fv), .serial_out(ser), .serial_out_complement(ser_n),
        .serial_active(ser_act), .std_625(std_625));

    video_link_partner u_partner (
        .sys_clk(sys_clk), .rstn(rstn), .ser_in(ser), .ser_inv(ser_n), .ser_on(ser_act),
        .par(pout_word), .pix_ready(pix_ready), .pix_valid(pix_valid), .pix_data(pix_data),
        .pkt_stb(pkt_stb), .pkt(pkt), .pkt_ref(pkt_ref), .inv_ok(inv_ok));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [7:0] xy(input logic f, input logic v, input logic h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    // Expected {field, blank} by line number
    function automatic logic [1:0] fv_of(input int ln, input logic s);
        if (!s)
            return (ln <= 3) ? 2'b11 : (ln <= 19) ? 2'b01 : (ln <= 263) ? 2'b00 :
                   (ln <= 265) ? 2'b01 : (ln <= 282) ? 2'b11 : 2'b10;
        return (ln <= 22) ? 2'b01 : (ln <= 310) ? 2'b00 : (ln <= 312) ? 2'b01 :
               (ln <= 335) ? 2'b11 : (ln <= 623) ? 2'b10 : 2'b11;
    endfunction

    // Locks line count on first active line of field 0
    always @(negedge sys_clk) begin
        if (pkt_stb)
            pk_cnt++;
        if (pkt_stb && scan_on) begin
            pe = {1'b0, pkt_ref.fv, pkt_ref.lv, pkt_ref.data, 1'b1};
            check_val("packet", {4'h0, pe}, {4'h0, pkt});
            if (act_left > 0) begin
                act_left--;
                if (img_line && have_prev)
                    check_val("pixel", {8'h00, prev + 8'h01}, {8'h00, pkt[8:1]});
                if (img_line) begin
                    prev = pkt[8:1];
                    have_prev = 1'b1;
                end
            end
            if (hist == 24'hFF0000) begin
                if (!synced && pkt[5] && pkt[7:6] == 2'b00 && lastv) begin
                    synced = 1'b1;
                    hx = 1'b1;
                    cur_line = p625 ? 23 : 20;
                end else if (synced && hx)
                    cur_line++;
                lastv = pkt[6];
                if (synced) begin
                    fvx = fv_of(cur_line, p625);
                    check_val("code", {8'h00, xy(fvx[1], fvx[0], hx)}, {8'h00, pkt[8:1]});
                    check_val("frame valid", {15'h0, ~fvx[0]}, {15'h0, pkt[10]});
                    hx = ~hx;
                end
                if (pkt[5]) begin
                    img_line = img_pend;
                    img_pend = 1'b0;
                end else
                    act_left = 4;
            end
            hist = {hist[15:0], pkt[8:1]};
        end
        if (line_req && synced && cur_line < (p625 ? 300 : 270)) begin
            n_req++;
            if (n_req == 1)
                first_req = cur_line + 1;
            last_req = cur_line + 1;
            rw = 9'((cur_line + 1 - (p625 ? 47 : 21)) * 2);
            if (cfg_vm)
                rw = 9'h1DF - rw;
            check_val("row", {7'h00, rw}, {7'h00, req_row});
            check_val("reverse", {15'h0, hm_pin | cfg_hm}, {15'h0, req_reverse});
        end
        if (line_req)
            img_pend = 1'b1;
    end

    task automatic run_frame(input logic s, input int upto);
        int k;
        @(posedge sys_clk);
        rstn <= 1'b0;
        std_pin <= s;
        hm_pin <= !s;
        cfg_hm <= s;
        cfg_vm <= s;
        p625 = s;
        {synced, lastv, img_pend, img_line, have_prev, hist} = '0;
        {cur_line, n_req, first_req, last_req, act_left, k} = '0;
        repeat (4) @(negedge sys_clk);
        check_val("reset", 16'h0000, {14'h0, ser_act, line_req});
        @(posedge sys_clk);
        rstn <= 1'b1;
        scan_on = 1'b1;
        while (cur_line < upto && k < 60000) begin
            @(negedge sys_clk);
            k++;
        end
        scan_on = 1'b0;
        check_val("standard", {15'h0, s}, {15'h0, std_625});
        check_val("first image", s ? 16'h002F : 16'h0015, first_req[15:0]);
        check_val("last image", s ? 16'h011E : 16'h0104, last_req[15:0]);
        check_val("image lines", 16'h00F0, n_req[15:0]);
        $display("frame %0d done", s);
    endtask

    initial begin
        {rstn, std_pin, stby, hm_pin, cfg_dis, cfg_hm, cfg_vm, cfg_mux, scan_on} = '0;
        en_pin = 1'b1;
        {n_fail, n_checks, pk_cnt, c0, css, cfe, craw, dck, din} = '0;
        run_frame(1'b0, 284);
        run_frame(1'b1, 338);
        for (int c = 0; c < 3; c++) begin
            @(posedge sys_clk);
            en_pin <= (c != 0);
            cfg_dis <= (c == 1);
            stby <= (c == 2);
            repeat (30) @(negedge sys_clk);
            check_val("link off", 16'h0000, {13'h0, ser_act, ser, ser_n});
            @(posedge sys_clk);
            en_pin <= 1'b1;
            cfg_dis <= 1'b0;
            stby <= 1'b0;
            repeat (30) @(negedge sys_clk);
            check_val("link on", 16'h0001, {15'h0, ser_act});
        end
        $display("link test done");
        c0 = pk_cnt;
        repeat (1200) @(negedge sys_clk);
        check_val("packet rate", 16'h0064, 16'(pk_cnt - c0));
        check_val("complement", 16'h0001, {15'h0, inv_ok});
        @(posedge sys_clk);
        cfg_mux <= 1'b1;
        {craw, cfe} <= 2'h3;
        din <= 8'h5A;
        @(negedge sys_clk);
        check_val("pixel ready", 16'h0000, {15'h0, pix_ready});
        repeat (4400) @(negedge sys_clk);
        while (!lv) @(negedge sys_clk);
        check_val("raw input", 16'h005A, {8'h00, pout_data});
        $display("rate and input test done");
        tally_and_finish;
    end

    initial begin
        repeat (98000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish;
    end
endmodule
